// ### logic/sppx_defines.svh
// constants for the setup and pixel pipeline
`ifndef SPPX_DEFINES_SVH
`define SPPX_DEFINES_SVH
`define SPPX_FIFO_DEPTH   32
`define SPPX_XY_W         12
`define SPPX_LUT_ENTRIES  256
`define SPPX_NSTAGE       14
`define SPPX_FRAC_BITS    16
`define SPPX_FLT_BIAS     8'h7f
`define SPPX_FLT_MANT     23
`define SPPX_VSLOT_NUM    3
// stage enable bit positions, pipeline order
`define SPPX_ST_CLIP      0
`define SPPX_ST_STIPPLE   1
`define SPPX_ST_DEPTH     2
`define SPPX_ST_TEXADDR   3
`define SPPX_ST_CKEY      4
`define SPPX_ST_DUPD      5
`define SPPX_ST_COLOR     6
`define SPPX_ST_TEXAPP    7
`define SPPX_ST_FOG       8
`define SPPX_ST_TRANSP    9
`define SPPX_ST_DITHER    10
`define SPPX_ST_LOGIC     11
`define SPPX_ST_FBWR      12
`define SPPX_ST_STATS     13
`endif

// ### logic/sppx_pkg.sv
// types shared by the setup and pixel pipeline
package sppx_pkg;
    `include "sppx_defines.svh"
    typedef enum logic [3:0] {
        SPPX_PRIM_POINT = 4'h1,
        SPPX_PRIM_LINE  = 4'h2,
        SPPX_PRIM_TRI   = 4'h4,
        SPPX_PRIM_RECT  = 4'h8
    } sppx_prim_t;
    // one pixel word travelling down the chain
    typedef struct packed {
        logic [`SPPX_XY_W-1:0] x;
        logic [`SPPX_XY_W-1:0] y;
        logic [15:0]           z;
        logic [31:0]           rgba;
        logic [7:0]            fog;
        logic [15:0]           tex;
        logic                  last;
    } sppx_pix_t;
    // one vertex as delivered by the host command path
    typedef struct packed {
        logic [31:0] x;
        logic [31:0] y;
        logic [31:0] z;
        logic [31:0] rgba;
        logic [7:0]  fog;
        logic [15:0] tex;
    } sppx_vtx_t;
endpackage : sppx_pkg

// ### logic/sppx_fifo_if.sv
// valid/ready carrier between pipeline and fifo
`timescale 1ns/1ps
interface sppx_fifo_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sppx_fifo_if

// ### logic/sppx_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module sppx_fifo
    import sppx_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 32
)(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // fill and drain sides
    sppx_fifo_if.snk wr,
    sppx_fifo_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } sppx_fst_t;
    sppx_fst_t    st_r;
    sppx_fst_t    st_nxt;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    // honest full and empty from the count
    assign wr.ready = (st_r.cnt < (AW+1)'(DEPTH));
    assign rd.valid = (st_r.cnt != '0);
    assign rd.data  = mem[st_r.rp];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // pointer and count update
    always_comb
    begin
        st_nxt = st_r;
        if (push)
            st_nxt.wp = st_r.wp + 1'b1;
        if (pop)
            st_nxt.rp = st_r.rp + 1'b1;
        st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
        if (push)
            mem[st_r.wp] <= wr.data;
    end

    // never more than depth words held
    fifo_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
        st_r.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : sppx_fifo

// ### logic/sppx_pipe.sv
// setup, rasterizer and per-pixel chain of the rendering engine
`timescale 1ns/1ps
module sppx_pipe
    import sppx_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    // vertex input from the host command path
    input  wire logic                   vtx_valid,
    output logic                        vtx_ready,
    input  wire sppx_vtx_t              vtx_data,
    input  wire logic                   vtx_float,
    input  wire logic                   vtx_reuse,
    input  wire sppx_prim_t             prim_kind,
    // static configuration
    input  wire logic [`SPPX_NSTAGE-1:0] stage_en,
    input  wire logic [`SPPX_XY_W-1:0]  clip_xmax,
    input  wire logic [`SPPX_XY_W-1:0]  clip_ymax,
    input  wire logic [31:0]            stipple_pat,
    input  wire logic [7:0]             ckey_val,
    input  wire logic [15:0]            depth_buf,
    input  wire logic [31:0]            tex_data,
    input  wire logic [7:0]             lut_idx,
    input  wire logic [31:0]            lut_wdata,
    input  wire logic                   lut_we,
    // pixel output towards frame memory
    output logic                        pix_valid,
    input  wire logic                   pix_ready,
    output sppx_pix_t                   pix_data,
    output logic                        tex_req,
    output logic [15:0]                 depth_wr,
    output logic                        depth_we,
    output logic [`SPPX_XY_W-1:0]       ext_xmax,
    output logic [`SPPX_XY_W-1:0]       ext_ymax
);
    // ================================================================
    // state
    // ================================================================
    typedef enum logic [2:0] {
        SPPX_S_LOAD  = 3'h1,
        SPPX_S_SETUP = 3'h2,
        SPPX_S_RAST  = 3'h4
    } sppx_st_t;

    typedef struct packed {
        sppx_st_t                     st;
        sppx_prim_t                   kind;
        logic [1:0]                   nv;
        sppx_vtx_t [2:0]              v;
        logic [`SPPX_XY_W-1:0]        cx;
        logic [`SPPX_XY_W-1:0]        cy;
        logic [`SPPX_XY_W-1:0]        x0;
        logic [`SPPX_XY_W-1:0]        x1;
        logic [`SPPX_XY_W-1:0]        y1;
        logic [31:0]                  dz;
        logic [`SPPX_NSTAGE-1:0]      pv;
        sppx_pix_t [`SPPX_NSTAGE-1:0] pd;
        logic                         tq;
        logic [15:0]                  dw;
        logic                         dwe;
        logic [`SPPX_XY_W-1:0]        ex;
        logic [`SPPX_XY_W-1:0]        ey;
    } sppx_state_t;

    sppx_state_t s_r;
    sppx_state_t s_nxt;
    logic [31:0] lut [`SPPX_LUT_ENTRIES];
    logic        rast_v;
    sppx_pix_t   rast_d;
    logic        adv  [`SPPX_NSTAGE+1];
    logic        keep [`SPPX_NSTAGE];
    logic        fifo_rdy;

    sppx_fifo_if #(.W($bits(sppx_pix_t))) f_in  ();
    sppx_fifo_if #(.W($bits(sppx_pix_t))) f_out ();

    // ================================================================
    // arithmetic helpers
    // ================================================================
    // fixed 16.16 to single float, vertices are held in float; setup turns vertex 0 z to fixed
    function automatic logic [31:0] sppx_to_flt(input logic [31:0] v);
        logic [31:0] a;
        logic [7:0]  e;
        int          msb;
        a   = v[31] ? -v : v;
        msb = 0;
        for (int i = 0; i < 32; i++)
            if (a[i])
                msb = i;
        e = 8'(msb - `SPPX_FRAC_BITS) + `SPPX_FLT_BIAS;
        if (a == '0)
            sppx_to_flt = '0;
        else
            sppx_to_flt = {v[31], e, 23'((a << (31 - msb)) >> 8)};
    endfunction : sppx_to_flt

    // float to fixed 16.16, high precision result for raster
    function automatic logic [31:0] sppx_to_fix(input logic [31:0] f);
        logic [55:0] m;
        int          sh;
        m  = {32'h0, 1'b1, f[22:0]};
        sh = int'(f[30:23]) - int'(`SPPX_FLT_BIAS) + `SPPX_FRAC_BITS
             - `SPPX_FLT_MANT;
        if (f[30:23] == 8'h0)
            m = '0;
        else if (sh >= 0)
            m = m << sh;
        else
            m = m >> (-sh);
        sppx_to_fix = f[31] ? -m[31:0] : m[31:0];
    endfunction : sppx_to_fix

    // screen pixel coordinate from a fixed value
    function automatic logic [`SPPX_XY_W-1:0] sppx_pix(input logic [31:0] f);
        sppx_pix = f[`SPPX_FRAC_BITS +: `SPPX_XY_W];
    endfunction : sppx_pix

    // ================================================================
    // colour lookup table
    // ================================================================
    // lookup table write
    always_ff @(posedge mclk)
    begin
        if (lut_we)
            lut[lut_idx] <= lut_wdata;
    end

    // ================================================================
    // handshake per stage boundary
    // ================================================================
    // stage advances when it is empty or when its successor frees up
    always_comb
    begin
        adv[`SPPX_NSTAGE] = fifo_rdy;
        for (int i = `SPPX_NSTAGE - 1; i >= 0; i--)
            adv[i] = !s_r.pv[i] || adv[i+1];
    end

    // test stages drop failing pixels when enabled
    always_comb
    begin
        for (int i = 0; i < `SPPX_NSTAGE; i++)
            keep[i] = 1'b1;
        keep[`SPPX_ST_CLIP] = !stage_en[`SPPX_ST_CLIP]
            || (s_r.pd[0].x <= clip_xmax && s_r.pd[0].y <= clip_ymax);
        keep[`SPPX_ST_STIPPLE] = !stage_en[`SPPX_ST_STIPPLE]
            || stipple_pat[{s_r.pd[1].y[1:0], s_r.pd[1].x[2:0]}];
        keep[`SPPX_ST_DEPTH] = !stage_en[`SPPX_ST_DEPTH]
            || (s_r.pd[2].z < depth_buf);
        keep[`SPPX_ST_CKEY] = !stage_en[`SPPX_ST_CKEY]
            || (s_r.pd[4].rgba[7:0] != ckey_val);
    end

    assign rast_v = (s_r.st == SPPX_S_RAST);
    always_comb
    begin
        rast_d      = '0;
        rast_d.x    = s_r.cx;
        rast_d.y    = s_r.cy;
        rast_d.z    = s_r.v[0].z[`SPPX_FRAC_BITS +: 16];
        rast_d.rgba = s_r.v[0].rgba;
        rast_d.fog  = s_r.v[0].fog;
        rast_d.tex  = s_r.v[0].tex;
        rast_d.last = (s_r.cx == s_r.x1) && (s_r.cy == s_r.y1);
    end

    // ================================================================
    // next state
    // ================================================================
    always_comb
    begin
        sppx_pix_t p;
        logic      done;
        p     = '0;
        done  = 1'b0;
        s_nxt = s_r;
        s_nxt.dwe = 1'b0;
        s_nxt.tq  = 1'b0;
        case (s_r.st)
            SPPX_S_LOAD:
            begin
                if (vtx_valid)
                begin
                    // vertex captured, fixed input made float
                    s_nxt.v[s_r.nv] = vtx_data;
                    if (!vtx_float)
                    begin
                        s_nxt.v[s_r.nv].x = sppx_to_flt(vtx_data.x);
                        s_nxt.v[s_r.nv].y = sppx_to_flt(vtx_data.y);
                        s_nxt.v[s_r.nv].z = sppx_to_flt(vtx_data.z);
                    end
                    s_nxt.kind = prim_kind;
                    if ((prim_kind == SPPX_PRIM_POINT)
                        || (prim_kind != SPPX_PRIM_TRI && s_r.nv == 2'h1)
                        || s_r.nv == 2'h2)
                        s_nxt.st = SPPX_S_SETUP;
                    else
                        s_nxt.nv = s_r.nv + 1'b1;
                end
            end
            SPPX_S_SETUP:
            begin
                // bounding span and depth slope, float to fixed
                s_nxt.x0 = sppx_pix(sppx_to_fix(s_r.v[0].x));
                s_nxt.cx = sppx_pix(sppx_to_fix(s_r.v[0].x));
                s_nxt.cy = sppx_pix(sppx_to_fix(s_r.v[0].y));
                s_nxt.x1 = sppx_pix(sppx_to_fix(s_r.v[s_r.nv].x));
                s_nxt.y1 = sppx_pix(sppx_to_fix(s_r.v[s_r.nv].y));
                s_nxt.dz = sppx_to_fix(s_r.v[s_r.nv].z)
                           - sppx_to_fix(s_r.v[0].z);
                s_nxt.v[0].z = sppx_to_fix(s_r.v[0].z);
                s_nxt.st = SPPX_S_RAST;
            end
            SPPX_S_RAST:
            begin
                // walk the covered span row by row
                if (adv[0])
                begin
                    if (rast_d.last)
                        done = 1'b1;
                    else if (s_r.cx == s_r.x1)
                    begin
                        s_nxt.cx = s_r.x0;
                        s_nxt.cy = s_r.cy + 1'b1;
                    end
                    else
                        s_nxt.cx = s_r.cx + 1'b1;
                end
                // next primitive loads while pixels still drain
                if (done)
                begin
                    s_nxt.st = SPPX_S_LOAD;
                    // strips keep the last two vertices
                    if (vtx_reuse && s_r.nv != 2'h0)
                    begin
                        // slide by one: lines refill slot 1, strips slot 2
                        s_nxt.v[0] = s_r.v[1];
                        s_nxt.v[1] = s_r.v[2];
                        s_nxt.nv   = s_r.nv;
                    end
                    else
                        s_nxt.nv = 2'h0;
                end
            end
            default:
                s_nxt.st = SPPX_S_LOAD;
        endcase

        for (int i = `SPPX_NSTAGE - 1; i >= 0; i--)
        begin
            if (adv[i])
            begin
                p = (i == 0) ? rast_d : s_r.pd[i-1];
                s_nxt.pv[i] = (i == 0) ? rast_v
                              : (s_r.pv[i-1] && keep[i-1]);
                s_nxt.pd[i] = p;
            end
        end
        // texture fetch only for depth survivors
        if (s_r.pv[`SPPX_ST_TEXADDR] && adv[`SPPX_ST_TEXADDR+1]
            && stage_en[`SPPX_ST_TEXADDR])
            s_nxt.tq = 1'b1;
        if (s_r.pv[`SPPX_ST_DUPD] && adv[`SPPX_ST_DUPD+1]
            && stage_en[`SPPX_ST_DUPD])
        begin
            s_nxt.dwe = 1'b1;
            s_nxt.dw  = s_r.pd[`SPPX_ST_DUPD].z;
        end
        // value-changing stages act only when enabled
        if (stage_en[`SPPX_ST_COLOR] && adv[`SPPX_ST_COLOR+1])
            s_nxt.pd[`SPPX_ST_COLOR+1].rgba =
                lut[s_r.pd[`SPPX_ST_COLOR].rgba[7:0]];
        if (stage_en[`SPPX_ST_TEXAPP] && adv[`SPPX_ST_TEXAPP+1])
            s_nxt.pd[`SPPX_ST_TEXAPP+1].rgba =
                s_r.pd[`SPPX_ST_TEXAPP].rgba ^ tex_data;
        if (stage_en[`SPPX_ST_FOG] && adv[`SPPX_ST_FOG+1])
            s_nxt.pd[`SPPX_ST_FOG+1].rgba[31:24] =
                s_r.pd[`SPPX_ST_FOG].fog;
        if (stage_en[`SPPX_ST_DITHER] && adv[`SPPX_ST_DITHER+1])
            s_nxt.pd[`SPPX_ST_DITHER+1].rgba[0] =
                s_r.pd[`SPPX_ST_DITHER].x[0] ^ s_r.pd[`SPPX_ST_DITHER].y[0];
        if (stage_en[`SPPX_ST_LOGIC] && adv[`SPPX_ST_LOGIC+1])
            s_nxt.pd[`SPPX_ST_LOGIC+1].rgba =
                ~s_r.pd[`SPPX_ST_LOGIC].rgba;
        // extent statistics on the last stage
        if (stage_en[`SPPX_ST_STATS] && s_r.pv[`SPPX_NSTAGE-1] && fifo_rdy)
        begin
            if (s_r.pd[`SPPX_NSTAGE-1].x > s_r.ex)
                s_nxt.ex = s_r.pd[`SPPX_NSTAGE-1].x;
            if (s_r.pd[`SPPX_NSTAGE-1].y > s_r.ey)
                s_nxt.ey = s_r.pd[`SPPX_NSTAGE-1].y;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s_r    <= '0;
            s_r.st <= SPPX_S_LOAD;
        end
        else
            s_r <= s_nxt;
    end

    // ================================================================
    // output fifo and ports
    // ================================================================
    // framebuffer-bound pixels buffered; full fifo stalls the chain
    assign f_in.valid = s_r.pv[`SPPX_NSTAGE-1];
    assign f_in.data  = s_r.pd[`SPPX_NSTAGE-1];
    assign fifo_rdy   = f_in.ready;
    sppx_fifo #(.W($bits(sppx_pix_t)), .DEPTH(`SPPX_FIFO_DEPTH)) u_fifo (
        .mclk (mclk),
        .nrst (nrst),
        .wr   (f_in),
        .rd   (f_out)
    );

    // output register slice keeps outputs flopped
    assign f_out.ready = !pix_valid || pix_ready;
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pix_valid <= 1'b0;
            pix_data  <= '0;
        end
        else if (f_out.ready)
        begin
            pix_valid <= f_out.valid;
            pix_data  <= f_out.data;
        end
    end
    assign vtx_ready = (s_r.st == SPPX_S_LOAD);
    assign tex_req   = s_r.tq;
    assign depth_wr  = s_r.dw;
    assign depth_we  = s_r.dwe;
    assign ext_xmax  = s_r.ex;
    assign ext_ymax  = s_r.ey;

    // ================================================================
    // checks
    // ================================================================
    sequence depth_fail_s;
        stage_en[`SPPX_ST_DEPTH] && s_r.pv[`SPPX_ST_DEPTH]
        && !keep[`SPPX_ST_DEPTH] && adv[`SPPX_ST_DEPTH+1];
    endsequence
    depth_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
        depth_fail_s |=> !s_r.pv[`SPPX_ST_DEPTH+1])
        else $error("failed pixel not dropped");
    stall_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
        else $error("output changed under stall");
    vtx_load_a: assert property (@(posedge mclk) disable iff (!nrst)
        vtx_valid && vtx_ready && prim_kind == SPPX_PRIM_POINT
        |=> s_r.st == SPPX_S_SETUP ##1 s_r.st == SPPX_S_RAST)
        else $error("point not set up in two cycles");
    bypass_col_a: assert property (@(posedge mclk) disable iff (!nrst)
        !stage_en[`SPPX_ST_COLOR] && adv[`SPPX_ST_COLOR+1]
        && s_r.pv[`SPPX_ST_COLOR] |=> s_r.pd[`SPPX_ST_COLOR+1].rgba
        == $past(s_r.pd[`SPPX_ST_COLOR].rgba))
        else $error("bypassed stage changed colour");
    prim_overlap_a: assert property (@(posedge mclk) disable iff (!nrst)
        s_r.st == SPPX_S_RAST && adv[0] && rast_d.last
        |=> vtx_ready)
        else $error("load blocked by draining pixels");
    chain_adv_a: assert property (@(posedge mclk) disable iff (!nrst)
        s_r.pv[0] && adv[1] && keep[`SPPX_ST_CLIP] |=> s_r.pv[1])
        else $error("pixel lost between stages");
    rast_walk_a: assert property (@(posedge mclk) disable iff (!nrst)
        s_r.st == SPPX_S_SETUP |=> rast_v ##1 s_r.pv[0])
        else $error("raster did not issue pixel");
    tex_req_a: assert property (@(posedge mclk) disable iff (!nrst)
        tex_req |-> $past(s_r.pv[`SPPX_ST_TEXADDR]))
        else $error("texture request without surviving pixel");
endmodule : sppx_pipe

// ### test/sppx_mem_model.sv
// frame memory side model taking pixels with selectable stalls
`timescale 1ns/1ps
module sppx_mem_model
    import sppx_pkg::*;
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       nrst,
    // pixel stream; mode 0 prompt, 1 one in three, 2 stalled
    input wire logic       pix_valid,
    output logic           pix_ready,
    input wire sppx_pix_t  pix_data,
    input wire logic [1:0] mode
);
    sppx_pix_t  got[$];
    logic [1:0] phase_r;

    // ready pattern; a slow sink must not lose or double a pixel
    // handshake acceptance
    always @(posedge mclk)
    begin
        if (pix_valid === 1'b1 && pix_ready === 1'b1)
            got.push_back(pix_data);
        phase_r   <= (!nrst || phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
        pix_ready <= nrst && (mode == 2'h0 || (mode == 2'h1 && phase_r == 0));
    end
endmodule : sppx_mem_model

// ### test/sppx_pipe_tb.sv
// self-checking bench for the setup and pixel pipeline
`timescale 1ns/1ps
`include "sppx_defines.svh"
module sppx_pipe_tb;
    import sppx_pkg::*;
    // stimulus and observed signals
    logic                    mclk, nrst, vtx_valid, vtx_ready, vtx_float;
    logic                    lut_we, pix_valid, pix_ready, tex_req, depth_we;
    logic                    vtx_reuse;
    logic [`SPPX_NSTAGE-1:0] stage_en;
    logic [`SPPX_XY_W-1:0]   clip_xmax, ext_xmax, ext_ymax;
    logic [15:0]             depth_wr, depth_buf;
    logic [7:0]              lut_idx;
    logic [31:0]             lut_wdata, c;
    logic [1:0]              mode;
    sppx_vtx_t               vtx_data;
    sppx_prim_t              prim_kind;
    sppx_pix_t               pix_data;
    int                      err_count, check_count, tex_cnt, t0;

    sppx_pipe i_sppx_pipe (.mclk(mclk), .nrst(nrst), .vtx_valid(vtx_valid),
        .vtx_ready(vtx_ready), .vtx_data(vtx_data), .vtx_float(vtx_float),
        .vtx_reuse(vtx_reuse), .prim_kind(prim_kind), .stage_en(stage_en),
        .clip_xmax(clip_xmax), .clip_ymax(12'hfff), .stipple_pat(32'h0),
        .ckey_val(8'h00), .depth_buf(depth_buf), .tex_data(32'h0),
        .lut_idx(lut_idx), .lut_wdata(lut_wdata), .lut_we(lut_we),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .tex_req(tex_req), .depth_wr(depth_wr), .depth_we(depth_we),
        .ext_xmax(ext_xmax), .ext_ymax(ext_ymax));

    sppx_mem_model i_sppx_mem_model (.mclk(mclk), .nrst(nrst),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .mode(mode));

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // texture fetch pulses
    always @(posedge mclk)
        if (tex_req === 1'b1)
            tex_cnt++;

    // ==================================================
    // checking and control tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic chk_val(input logic [31:0] g, e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_val

    task automatic chk_pix(input int i, input logic [11:0] x, y,
                           input logic [31:0] k, input logic l);
        sppx_pix_t p;
        p = i_sppx_mem_model.got[i];
        check_count++;
        if ({p.x, p.y, p.rgba, p.last} !== {x, y, k, l})
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time,
                     {p.x, p.y, p.rgba, p.last}, {x, y, k, l});
        end
    endtask : chk_pix

    task automatic hang();
        chk_val(32'h0, 32'h1);
        wrap_up();
    endtask : hang

    function automatic logic [31:0] fx(input int n);
        return {n[15:0], 16'h0000};
    endfunction : fx

    // new scenario: empty capture, set stages and primitive kind
    task automatic fresh(input int en, input sppx_prim_t k, input logic f);
        i_sppx_mem_model.got.delete();
        stage_en  <= en[`SPPX_NSTAGE-1:0];
        prim_kind <= k;
        vtx_float <= f;
        mode      <= 2'h0;
        @(posedge mclk);
    endtask : fresh

    // one vertex, held until accepted
    task automatic send(input logic [31:0] x, y, z, k);
        @(posedge mclk);
        vtx_valid <= 1'b1;
        vtx_data  <= '{x: x, y: y, z: z, rgba: k, fog: 8'h00, tex: 16'h0};
        for (int i = 0; i <= 200; i++)
        begin
            @(posedge mclk);
            if (vtx_ready === 1'b1)
                break;
            if (i == 200)
                hang();
        end
        vtx_valid <= 1'b0;
    endtask : send

    // wait for n pixels, then make sure no extra one follows
    task automatic expect_pix(input int n);
        for (int i = 0; i_sppx_mem_model.got.size() < n; i++)
        begin
            @(posedge mclk);
            if (i == 2000)
                hang();
        end
        repeat (40) @(posedge mclk);
        chk_val(i_sppx_mem_model.got.size(), n);
    endtask : expect_pix

    // ==================================================
    // scenarios
    task automatic t_basic();
        c = 32'hcafe0012;
        fresh(0, SPPX_PRIM_POINT, 1'b0);
        send(fx(3), fx(4), fx(0), c);
        expect_pix(1);
        chk_pix(0, 12'h003, 12'h004, c, 1'b1); // bypassed chain
        fresh(0, SPPX_PRIM_POINT, 1'b1);
        send(32'h40a00000, 32'h40000000, 32'h0, c);
        expect_pix(1);
        chk_pix(0, 12'h005, 12'h002, c, 1'b1); // float input
        $display("test basic done");
    endtask : t_basic

    task automatic t_kinds();
        fresh(0, SPPX_PRIM_LINE, 1'b0);
        send(fx(0), fx(0), fx(0), c);
        send(fx(2), fx(0), fx(0), c);
        expect_pix(3);
        chk_pix(2, 12'h002, 12'h000, c, 1'b1); // line span
        fresh(0, SPPX_PRIM_TRI, 1'b0);
        send(fx(0), fx(0), fx(0), c);
        send(fx(1), fx(0), fx(0), c);
        send(fx(1), fx(1), fx(0), c);
        expect_pix(4);
        chk_pix(0, 12'h000, 12'h000, c, 1'b0); // triangle start
        chk_pix(3, 12'h001, 12'h001, c, 1'b1); // triangle end
        $display("test kinds done");
    endtask : t_kinds

    // fifo filled against a stalled sink, then drained slowly
    task automatic t_fill();
        fresh(1 << `SPPX_ST_STATS, SPPX_PRIM_RECT, 1'b0);
        mode <= 2'h2;
        send(fx(0), fx(0), fx(0), c);
        send(fx(19), fx(1), fx(0), c);
        repeat (100) @(posedge mclk);
        mode <= 2'h1;
        expect_pix(40);
        for (int i = 0; i < 40; i++)
            chk_pix(i, 12'(i % 20), 12'(i / 20), c, i == 39); // order
        chk_val(32'(ext_xmax), 32'h13); // extent
        chk_val(32'(ext_ymax), 32'h1); // extent
        $display("test fill done");
    endtask : t_fill

    task automatic t_drop();
        fresh(1 << `SPPX_ST_CLIP, SPPX_PRIM_POINT, 1'b0);
        clip_xmax <= 12'h00a;
        send(fx(100), fx(1), fx(0), c);
        send(fx(5), fx(1), fx(0), c);
        expect_pix(1);
        chk_pix(0, 12'h005, 12'h001, c, 1'b1); // clipped pixel gone
        fresh((1 << `SPPX_ST_DEPTH) | (1 << `SPPX_ST_TEXADDR),
              SPPX_PRIM_POINT, 1'b0);
        depth_buf <= 16'h0010;
        t0 = tex_cnt;
        send(fx(1), fx(1), 32'hffffffff, c);
        expect_pix(0);
        chk_val(tex_cnt - t0, 0); // no fetch after depth fail
        send(fx(1), fx(1), 32'h0, c);
        expect_pix(1);
        chk_val(tex_cnt - t0, 1); // fetch after depth pass
        $display("test drop done");
    endtask : t_drop

    task automatic t_lut();
        fresh(1 << `SPPX_ST_COLOR, SPPX_PRIM_POINT, 1'b0);
        lut_we    <= 1'b1;
        lut_idx   <= 8'h22;
        lut_wdata <= 32'h11223344;
        @(posedge mclk);
        lut_we    <= 1'b0;
        send(fx(2), fx(2), fx(0), 32'h00000022);
        expect_pix(1);
        chk_pix(0, 12'h002, 12'h002, 32'h11223344, 1'b1); // lookup
        $display("test lut done");
    endtask : t_lut

    // second primitive enters while the first is held in the chain
    task automatic t_overlap();
        fresh(0, SPPX_PRIM_POINT, 1'b0);
        mode <= 2'h2;
        send(fx(1), fx(1), fx(0), 32'h11);
        send(fx(2), fx(2), fx(0), 32'h22);
        chk_val(i_sppx_mem_model.got.size(), 0);
        mode <= 2'h0;
        expect_pix(2);
        chk_pix(0, 12'h001, 12'h001, 32'h11, 1'b1); // first kept
        chk_pix(1, 12'h002, 12'h002, 32'h22, 1'b1); // second kept
        $display("test overlap done");
    endtask : t_overlap

    // polyline: the second segment starts from the shared middle vertex
    task automatic t_reuse();
        fresh(0, SPPX_PRIM_LINE, 1'b0);
        vtx_reuse <= 1'b1;
        send(fx(0), fx(0), fx(0), c);
        send(fx(1), fx(0), fx(0), c);
        send(fx(3), fx(0), fx(0), c);
        vtx_reuse <= 1'b0;
        expect_pix(5);
        chk_pix(2, 12'h001, 12'h000, c, 1'b0); // shared start
        chk_pix(4, 12'h003, 12'h000, c, 1'b1); // second end
        $display("test reuse done");
    endtask : t_reuse

    // ==================================================
    // main sequence
    initial
    begin
        err_count   = 0;
        check_count = 0;
        tex_cnt     = 0;
        nrst        = 1'b0;
        vtx_valid   = 1'b0;
        vtx_float   = 1'b0;
        vtx_reuse   = 1'b0;
        vtx_data    = '0;
        prim_kind   = SPPX_PRIM_POINT;
        stage_en    = '0;
        clip_xmax   = 12'hfff;
        depth_buf   = 16'hffff;
        lut_we      = 1'b0;
        lut_idx     = 8'h00;
        lut_wdata   = 32'h0;
        mode        = 2'h0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        t_basic(); // point through
        t_kinds(); // lines and triangles
        t_fill(); // stall and drain
        t_drop(); // dropped pixels
        t_lut(); // colour table
        t_overlap(); // primitives in flight
        t_reuse(); // shared vertices
        wrap_up();
    end
endmodule : sppx_pipe_tb
